/* File: design/async_timing_capture_trigger.sv */
`timescale 1ns/1ps

module async_timing_capture_trigger #(
   parameter int EXP_MAX = 5,
   parameter int HALT_W  = 16
) (
   input  wire logic                               clk,           // 10 MHz clock.
   input  wire logic                               rst_n,         // Synchronous reset, active low.
   input  wire logic [timing_capture_pkg::N_CH-1:0] probe,        // Probe channels, pins.
   input  wire logic                               external_trigger_input, // Pin.
   input  wire logic                               state_clk,     // Target state clock, pin.
   input  wire logic                               arm_cmd,       // Arm command with state clock.
   input  wire logic                               main_match,    // Main word match.
   input  wire logic                               main_trigger,  // Main section triggered.
   input  wire logic                               start,         // Start the program.
   input  wire logic                               user_stop,     // Stop the program.
   input  wire logic                               unconditional, // Program is only the arm.
   input  wire logic                               sync_mode,     // Sample on state clocks.
   input  wire timing_capture_pkg::event_cfg_t     evt_cfg,       // Event recognizer setup.
   input  wire timing_capture_pkg::timebase_cfg_t  tb_cfg,        // Sample period setup.
   input  wire logic                               halt_enable,   // Target halt selected.
   input  wire logic [HALT_W-1:0]                  halt_delay,    // Post-trigger state clocks.
   output logic [timing_capture_pkg::N_CH-1:0]     sample_data,   // Stored sample word.
   output logic [timing_capture_pkg::N_CH-1:0]     sample_glitch, // Stored glitch flags.
   output logic                                    sample_mark,   // Sample is the trigger point.
   output logic                                    sample_valid,  // Sample strobe.
   output logic                                    event_flag,    // Event to main section.
   output logic                                    main_event,    // Delayed main match.
   output logic                                    armed,         // Arm signal.
   output logic                                    trig_pulse,    // Trigger pulse.
   output logic                                    triggered,     // Trigger has occurred.
   output logic                                    period_error,  // Period was replaced.
   output logic                                    acq_running,   // Acquisition active.
   output logic                                    halt_out       // Target halt line.
);

   localparam int N      = timing_capture_pkg::N_CH;
   localparam int SET_W  = $clog2(timing_capture_pkg::SETTLE_CYC + 1);
   localparam int ARM_W  = $clog2(timing_capture_pkg::ARM_DELAY_CYC + 1);
   localparam int FILT_W = 8;

   if (HALT_W < 1 || HALT_W > 32) $error("HALT_W out of range.");
   if (timing_capture_pkg::FILTER_STEPS * timing_capture_pkg::FILTER_STEP_CYC >= 2 ** FILT_W)
      $error("Filter counter too narrow.");

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      timing_capture_pkg::seq_state_t st;
      logic [N-1:0]        prb_prev;
      logic [N-1:0][1:0]   tcnt;
      logic [N-1:0]        glitch;
      logic [FILT_W-1:0]   filt_cnt;
      logic                word_f;
      logic                evt;
      logic                evt_prev;
      logic                sclk_prev;
      logic [1:0]          sclk_cnt;
      logic [SET_W-1:0]    settle;
      logic [1:0]          arm_pipe;
      logic [1:0]          match_pipe;
      logic [ARM_W-1:0]    arm_dly;
      logic                armed;
      logic                pend;
      logic                first;
      logic [N-1:0]        s_data;
      logic [N-1:0]        s_glitch;
      logic                s_mark;
      logic                s_valid;
      logic                trig_pulse;
      logic                trig_done;
      logic                main_evt;
      logic                main_trig;
      logic [HALT_W-1:0]   halt_cnt;
      logic                halt;
   } cap_state_t;

   cap_state_t q;
   cap_state_t d;

   logic [N-1:0]      probe_s;
   logic              ext_s;
   logic [3:0]        ctl_s;
   logic              tb_tick;
   logic              tb_err;
   logic              state_tick;
   logic              sample_tick;
   logic              word_raw;
   logic              gterm;
   logic              all_dc;
   logic              accept;
   logic              hit;
   logic              pend_now;
   logic [N-1:0]      gnew;
   logic [1:0]        tc;
   logic [FILT_W-1:0] filt_lim;

   // ----------------------------------------------------------------
   // Input synchronisers and timebase
   // ----------------------------------------------------------------
   sync3 #(.W(N + 1)) u_sync_probe (
      .clk   (clk),
      .rst_n (rst_n),
      .din   ({external_trigger_input, probe}),
      .dout  ({ext_s, probe_s})
   );

   sync3 #(.W(4)) u_sync_ctl (
      .clk   (clk),
      .rst_n (rst_n),
      .din   ({main_trigger, main_match, arm_cmd, state_clk}),
      .dout  (ctl_s)
   );

   timebase_div #(.EXP_MAX(EXP_MAX), .CNT_W(20)) u_timebase (
      .clk          (clk),
      .rst_n        (rst_n),
      .restart      (start),
      .cfg          (tb_cfg),
      .tick         (tb_tick),
      .period_error (tb_err)
   );

   // The selected edge of the event output, never its level.
   function automatic logic edge_hit(input logic now, input logic prev, input logic fall);
      return fall ? (prev & ~now) : (now & ~prev);
   endfunction : edge_hit

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb
   begin
      d            = q;
      d.s_valid    = 1'b0;
      d.trig_pulse = 1'b0;
      tc           = 2'h0;
      gnew         = '0;
      d.sclk_prev  = ctl_s[0];
      state_tick   = ctl_s[0] & ~q.sclk_prev;
      sample_tick  = sync_mode ? state_tick : tb_tick;

      // Per-channel transition count over one sample period.
      d.prb_prev = probe_s;
      for (int i = 0; i < N; i++)
      begin
         tc = q.tcnt[i];
         if (probe_s[i] != q.prb_prev[i] && tc != 2'h2)
         begin
            tc = tc + 2'h1;
         end
         gnew[i] = (tc == 2'h2);
         if (sample_tick)
         begin
            d.tcnt[i] = 2'h0;
         end
         else
         begin
            d.tcnt[i] = tc;
         end
      end
      // The glitch becomes visible to the recognizer only after the sample that stores it.
      if (sample_tick)
      begin
         d.glitch = gnew;
      end

      word_raw = &((probe_s ~^ evt_cfg.word_value) | ~evt_cfg.word_care)
                 & (~evt_cfg.ext_care | (ext_s == evt_cfg.ext_value));
      filt_lim = FILT_W'(int'(evt_cfg.filter_steps) * timing_capture_pkg::FILTER_STEP_CYC);
      if (!word_raw)
      begin
         d.filt_cnt = '0;
         d.word_f   = 1'b0;
      end
      else if (q.filt_cnt >= filt_lim)
      begin
         d.word_f = 1'b1;
      end
      else
      begin
         d.filt_cnt = q.filt_cnt + FILT_W'(1);
      end

      gterm      = (evt_cfg.glitch_sel == '0) | |(q.glitch & evt_cfg.glitch_sel);
      d.evt      = q.word_f & gterm;
      d.evt_prev = q.evt;
      all_dc     = (evt_cfg.word_care == '0) & ~evt_cfg.ext_care & (evt_cfg.glitch_sel == '0);

      // Main section event and arm command, both on state clocks.
      if (state_tick)
      begin
         d.match_pipe = {q.match_pipe[0], ctl_s[2]};
         d.arm_pipe   = {q.arm_pipe[0], ctl_s[1]};
         d.main_evt   = q.match_pipe[1];
         if (q.sclk_cnt != 2'(timing_capture_pkg::STATE_CLKS_REQ))
         begin
            d.sclk_cnt = q.sclk_cnt + 2'h1;
         end
      end
      if (q.sclk_cnt == 2'(timing_capture_pkg::STATE_CLKS_REQ)
          && q.settle != SET_W'(timing_capture_pkg::SETTLE_CYC))
      begin
         d.settle = q.settle + SET_W'(1);
      end
      accept = q.armed & (unconditional
               | (q.settle == SET_W'(timing_capture_pkg::SETTLE_CYC)));
      hit      = accept & (edge_hit(q.evt, q.evt_prev, evt_cfg.fall_edge) | all_dc);
      pend_now = q.pend | hit;

      case (q.st)
         timing_capture_pkg::ST_IDLE:
         begin
            if (start)
            begin
               d.first    = 1'b1;
               d.pend     = 1'b0;
               d.sclk_cnt = 2'h0;
               d.settle   = '0;
               d.arm_pipe = 2'h0;
               d.arm_dly  = '0;
               d.trig_done = 1'b0;
               d.armed    = unconditional;
               d.st       = unconditional ? timing_capture_pkg::ST_ARMED : timing_capture_pkg::ST_RUN;
            end
         end
         timing_capture_pkg::ST_RUN:
         begin
            // With the state clock stopped no arm ever arrives.
            if (state_tick && q.arm_pipe[1])
            begin
               d.arm_dly = ARM_W'(timing_capture_pkg::ARM_DELAY_CYC);
            end
            else if (q.arm_dly != '0)
            begin
               d.arm_dly = q.arm_dly - ARM_W'(1);
               if (q.arm_dly == ARM_W'(1))
               begin
                  d.armed = 1'b1;
                  d.st    = timing_capture_pkg::ST_ARMED;
               end
            end
         end
         timing_capture_pkg::ST_ARMED:
         begin
            d.pend = pend_now;
         end
         timing_capture_pkg::ST_DONE:
         begin
            d.pend = 1'b0;
         end
         default:
         begin
            d.st = timing_capture_pkg::ST_IDLE;
         end
      endcase

      // Sample storage; the trigger marks the word taken at the next sample edge.
      if (sample_tick && q.st != timing_capture_pkg::ST_IDLE)
      begin
         if (q.first)
         begin
            d.first = 1'b0;
         end
         else
         begin
            d.s_valid  = 1'b1;
            d.s_data   = probe_s;
            d.s_glitch = gnew;
            d.s_mark   = (q.st == timing_capture_pkg::ST_ARMED) & pend_now;
            if (d.s_mark)
            begin
               d.trig_pulse = 1'b1;
               d.trig_done  = 1'b1;
               d.pend       = 1'b0;
               d.st         = timing_capture_pkg::ST_DONE;
            end
         end
      end

      // Halt follows the main section only.
      if (ctl_s[3])
      begin
         d.main_trig = 1'b1;
      end
      if (q.main_trig && state_tick && q.halt_cnt != halt_delay)
      begin
         d.halt_cnt = q.halt_cnt + HALT_W'(1);
      end
      d.halt = halt_enable & q.main_trig & (q.halt_cnt == halt_delay);

      if (user_stop)
      begin
         d.st        = timing_capture_pkg::ST_IDLE;
         d.armed     = 1'b0;
         d.pend      = 1'b0;
         d.main_trig = 1'b0;
         d.halt_cnt  = '0;
      end
      else if (start)
      begin
         d.main_trig = ctl_s[3];
         d.halt_cnt  = '0;
      end
      if (d.st == timing_capture_pkg::ST_IDLE)
      begin
         d.armed = 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         q    <= '0;
         q.st <= timing_capture_pkg::ST_IDLE;
      end
      else
      begin
         q <= d;
      end
   end

   assign sample_data   = q.s_data;
   assign sample_glitch = q.s_glitch;
   assign sample_mark   = q.s_mark;
   assign sample_valid  = q.s_valid;
   assign event_flag    = q.evt;
   assign main_event    = q.main_evt;
   assign armed         = q.armed;
   assign trig_pulse    = q.trig_pulse;
   assign triggered     = q.trig_done;
   assign period_error  = tb_err;
   assign acq_running   = (q.st != timing_capture_pkg::ST_IDLE);
   assign halt_out      = q.halt;

endmodule : async_timing_capture_trigger

/* File: design/sync3.sv */
`timescale 1ns/1ps

module sync3 #(
   parameter int W = 1
) (
   input  wire logic         clk,   // Clock.
   input  wire logic         rst_n, // Synchronous reset, active low.
   input  wire logic [W-1:0] din,   // Asynchronous input.
   output logic      [W-1:0] dout   // Filtered synchronous level.
);

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] val;
   } sync_state_t;

   sync_state_t q;
   sync_state_t d;

   if (W < 1) $error("sync3: W must be at least 1.");

   // A change counts only once the second and third stages agree.
   always_comb
   begin
      d     = q;
      d.s1  = din;
      d.s2  = q.s1;
      d.s3  = q.s2;
      if (q.s2 == q.s3)
      begin
         d.val = q.s3;
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         q <= '0;
      end
      else
      begin
         q <= d;
      end
   end

   assign dout = q.val;

endmodule : sync3

/* File: design/timebase_div.sv */
`timescale 1ns/1ps

module timebase_div #(
   parameter int EXP_MAX = 5,
   parameter int CNT_W   = 20
) (
   input  wire logic                          clk,          // Clock.
   input  wire logic                          rst_n,        // Synchronous reset, active low.
   input  wire logic                          restart,      // Restart the sample period.
   input  wire timing_capture_pkg::timebase_cfg_t cfg,      // Multiplier and exponent.
   output logic                               tick,         // One pulse per sample period.
   output logic                               period_error  // Requested period was replaced.
);

   typedef struct packed {
      logic [CNT_W-1:0] cnt;
      logic             tick;
      logic             err;
   } tb_state_t;

   tb_state_t        q;
   tb_state_t        d;
   logic [2:0]       mval;
   logic [2:0]       ev;
   logic [CNT_W-1:0] per;

   if (EXP_MAX < 1 || EXP_MAX > 7 || CNT_W < $clog2(5 * (10 ** EXP_MAX) + 1))
      $error("timebase_div: EXP_MAX or CNT_W out of range.");

   function automatic logic [CNT_W-1:0] period_cycles(input logic [2:0] m, input logic [2:0] e);
      int p;
      p = timing_capture_pkg::BASE_CYC * int'(m);
      for (int i = 0; i < EXP_MAX; i++)
      begin
         if (i < int'(e))
         begin
            p = p * 10;
         end
      end
      return CNT_W'(p);
   endfunction : period_cycles

   always_comb
   begin
      d     = q;
      d.err = 1'b0;
      ev    = cfg.exp_sel;
      case (cfg.mult_sel)
         timing_capture_pkg::MULT_1: mval = timing_capture_pkg::MULT_VAL_1;
         timing_capture_pkg::MULT_2: mval = timing_capture_pkg::MULT_VAL_2;
         timing_capture_pkg::MULT_5: mval = timing_capture_pkg::MULT_VAL_5;
         default:
         begin
            mval  = timing_capture_pkg::MULT_VAL_2;
            d.err = 1'b1;
         end
      endcase
      if (int'(ev) > EXP_MAX)
      begin
         ev    = 3'(EXP_MAX);
         d.err = 1'b1;
      end
      // The fastest combination is refused and the next one substituted.
      if (mval == timing_capture_pkg::MULT_VAL_1 && ev == timing_capture_pkg::EXP_MIN)
      begin
         mval  = timing_capture_pkg::MULT_VAL_2;
         d.err = 1'b1;
      end
      per = period_cycles(mval, ev);
      if (restart)
      begin
         d.cnt  = '0;
         d.tick = 1'b0;
      end
      else if (q.cnt >= per - CNT_W'(1))
      begin
         d.cnt  = '0;
         d.tick = 1'b1;
      end
      else
      begin
         d.cnt  = q.cnt + CNT_W'(1);
         d.tick = 1'b0;
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         q <= '0;
      end
      else
      begin
         q <= d;
      end
   end

   assign tick         = q.tick;
   assign period_error = q.err;

endmodule : timebase_div

/* File: pkg/timing_capture_pkg.sv */
package timing_capture_pkg;

   // ----------------------------------------------------------------
   // Clock and timing constants
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS   = 100;
   localparam int BASE_PERIOD_NS  = 10;
   localparam int BASE_CYC        = (BASE_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int ARM_DELAY_NS    = 60;
   localparam int ARM_DELAY_CYC   = (ARM_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SETTLE_US       = 60;
   localparam int SETTLE_CYC      = (SETTLE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int FILTER_STEP_NS  = 20;
   localparam int FILTER_MAX_NS   = 300;
   localparam int FILTER_STEPS    = FILTER_MAX_NS / FILTER_STEP_NS;
   localparam int FILTER_STEP_CYC = (FILTER_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int STATE_CLKS_REQ  = 2;
   localparam int N_CH            = 8;

   // ----------------------------------------------------------------
   // Timebase encodings
   // ----------------------------------------------------------------
   localparam logic [1:0] MULT_1     = 2'h0;
   localparam logic [1:0] MULT_2     = 2'h1;
   localparam logic [1:0] MULT_5     = 2'h2;
   localparam logic [2:0] MULT_VAL_1 = 3'h1;
   localparam logic [2:0] MULT_VAL_2 = 3'h2;
   localparam logic [2:0] MULT_VAL_5 = 3'h5;
   localparam logic [2:0] EXP_MIN    = 3'h0;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      ST_IDLE  = 4'h1,
      ST_RUN   = 4'h2,
      ST_ARMED = 4'h4,
      ST_DONE  = 4'h8
   } seq_state_t;

   typedef struct packed {
      logic [N_CH-1:0] word_value;
      logic [N_CH-1:0] word_care;
      logic            ext_value;
      logic            ext_care;
      logic [N_CH-1:0] glitch_sel;
      logic [3:0]      filter_steps;
      logic            fall_edge;
   } event_cfg_t;

   typedef struct packed {
      logic [1:0] mult_sel;
      logic [2:0] exp_sel;
   } timebase_cfg_t;

endpackage : timing_capture_pkg

/* File: sim/capture_props.sv */
`timescale 1ns/1ps

module capture_props #(
   parameter int EXP_MAX = 5,
   parameter int HALT_W  = 16
) (
   input wire logic                              clk,          // Clock.
   input wire logic                              rst_n,        // Reset.
   input wire timing_capture_pkg::timebase_cfg_t tb_cfg,       // Timebase.
   input wire logic                              halt_enable,  // Halt select.
   input wire logic                              sample_valid, // Strobe.
   input wire logic                              sample_mark,  // Mark.
   input wire logic                              armed,        // Armed.
   input wire logic                              trig_pulse,   // Trigger.
   input wire logic                              triggered,    // Triggered.
   input wire logic                              period_error, // Error.
   input wire logic                              acq_running,  // Running.
   input wire logic                              halt_out      // Halt.
);
   // ----------------------------------------------------------------
   // Properties
   // ----------------------------------------------------------------
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence bad_cfg_s;
      (tb_cfg == 5'h00) [*3];
   endsequence

   sequence ok_cfg_s;
      (tb_cfg == 5'h08) [*3];
   endsequence

   period_bad_a: assert property (bad_cfg_s |-> period_error)
      else $error("period error missing");
   period_ok_a: assert property (ok_cfg_s |-> !period_error)
      else $error("period error on legal period");
   trig_sample_a: assert property (trig_pulse |-> sample_valid && sample_mark)
      else $error("trigger without marked sample");
   trig_armed_a: assert property (trig_pulse |-> $past(armed))
      else $error("trigger while unarmed");
   trig_once_a: assert property (trig_pulse |=> !trig_pulse [*8])
      else $error("second trigger pulse");
   trig_level_a: assert property (trig_pulse |-> ##[0:1] triggered)
      else $error("triggered level missing");
   valid_pulse_a: assert property (sample_valid |=> !sample_valid)
      else $error("sample strobe too long");
   halt_cause_a: assert property (halt_out |-> $past(halt_enable))
      else $error("halt without halt select");
   idle_quiet_a: assert property (!acq_running && $past(!acq_running) |-> !sample_valid && !trig_pulse)
      else $error("activity while idle");
endmodule : capture_props

/* File: sim/main_section_model.sv */
`timescale 1ns/1ps

module main_section_model (
   input wire logic clk,                 // Clock.
   input wire logic run,                 // State clock enable.
   input wire logic arm_req,             // Arm at next state edge.
   input wire logic trig_req,            // Main trigger.
   output logic     state_clk    = 1'b0, // State clock.
   output logic     arm_cmd      = 1'b0, // Arm command.
   output logic     main_match   = 1'b0, // Word match.
   output logic     main_trigger = 1'b0  // Main triggered.
);
   // ----------------------------------------------------------------
   // State clock, 20 cycles a period, still while stopped
   // ----------------------------------------------------------------
   logic [4:0] cnt_q = 5'h00;

   always @(posedge clk)
   begin
      if (!run)
      begin
         cnt_q <= 5'h00;
         state_clk <= 1'b0;
         arm_cmd <= 1'b0;
         main_match <= 1'b0;
         main_trigger <= 1'b0;
      end
      else
      begin
         cnt_q <= (cnt_q == 5'h13) ? 5'h00 : cnt_q + 5'h01;
         state_clk <= (cnt_q < 5'h0A);
         // Qualifiers change at the falling edge to stay stable around the rise.
         if (cnt_q == 5'h0A)
         begin
            arm_cmd <= arm_req;
            main_match <= arm_req;
            main_trigger <= trig_req;
         end
      end
   end
endmodule : main_section_model

/* File: sim/testbench.sv */
`timescale 1ns/1ps

module testbench;
   logic                              clk;
   logic                              rst_n, start, user_stop, unconditional, halt_enable;
   logic                              run, arm_req, trig_req, ext, sync_mode;
   logic [7:0]                        probe;
   logic [15:0]                       halt_delay;
   timing_capture_pkg::event_cfg_t    evt_cfg;
   timing_capture_pkg::timebase_cfg_t tb_cfg;
   logic                              state_clk, arm_cmd, main_match, main_trigger;
   logic [7:0]                        sample_data, sample_glitch;
   logic                              sample_mark, sample_valid, event_flag, main_event, armed;
   logic                              trig_pulse, triggered, period_error, acq_running, halt_out;
   int                                errors, compares, cycles;

   async_timing_capture_trigger i_async_timing_capture_trigger (
      .clk(clk), .rst_n(rst_n), .probe(probe), .external_trigger_input(ext),
      .state_clk(state_clk), .arm_cmd(arm_cmd), .main_match(main_match),
      .main_trigger(main_trigger), .start(start), .user_stop(user_stop),
      .unconditional(unconditional), .sync_mode(sync_mode), .evt_cfg(evt_cfg),
      .tb_cfg(tb_cfg), .halt_enable(halt_enable), .halt_delay(halt_delay),
      .sample_data(sample_data), .sample_glitch(sample_glitch), .sample_mark(sample_mark),
      .sample_valid(sample_valid), .event_flag(event_flag), .main_event(main_event), .armed(armed),
      .trig_pulse(trig_pulse), .triggered(triggered), .period_error(period_error),
      .acq_running(acq_running), .halt_out(halt_out));

   main_section_model i_main_section_model (
      .clk(clk), .run(run), .arm_req(arm_req), .trig_req(trig_req), .state_clk(state_clk),
      .arm_cmd(arm_cmd), .main_match(main_match), .main_trigger(main_trigger));

   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task check(input string name, input logic [15:0] exp, input logic [15:0] got);
      compares++;
      if (got !== exp)
      begin
         errors++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask : check

   task tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick

   task wait_trig(input int lim, input logic [7:0] dat);
      int i;
      for (i = 0; i < lim && trig_pulse !== 1'b1; i++)
         tick(1);
      check("trig_pulse", 16'h0001, trig_pulse);
      check("sample_mark", 16'h0001, sample_mark);
      check("sample_data", {8'h00, dat}, sample_data);
      check("sample_glitch", 16'h0000, sample_glitch);
   endtask : wait_trig

   task give_verdict;
      if (errors == 0 && compares > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : give_verdict

   // ----------------------------------------------------------------
   // Clock, timeout and test sequence
   // ----------------------------------------------------------------
   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         errors++;
         give_verdict;
      end
   end

   initial
   begin
      rst_n = 1'b0; start = 1'b0; user_stop = 1'b0; unconditional = 1'b1; halt_enable = 1'b0;
      run = 1'b0; arm_req = 1'b0; trig_req = 1'b0; probe = 8'h00; halt_delay = 16'h0002;
      ext = 1'b0;
      sync_mode = 1'b0;
      evt_cfg = '0;
      tb_cfg = '0;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      tick(8);
      check("period_error", 16'h0001, period_error);
      @(posedge clk) tb_cfg <= 5'h08;
      tick(6);
      check("period_error", 16'h0000, period_error);
      @(posedge clk) start <= 1'b1;
      @(posedge clk) start <= 1'b0;
      wait_trig(40, 8'h00);
      check("armed", 16'h0001, armed);
      @(posedge clk) user_stop <= 1'b1;
      @(posedge clk) user_stop <= 1'b0;
      tick(3);
      check("acq_running", 16'h0000, acq_running);
      @(posedge clk) unconditional <= 1'b0;
      evt_cfg.word_care <= 8'h10;
      evt_cfg.word_value <= 8'h10;
      probe <= 8'h10;
      halt_enable <= 1'b1;
      run <= 1'b1;
      start <= 1'b1;
      @(posedge clk) start <= 1'b0;
      tick(100);
      check("triggered", 16'h0000, triggered);
      @(posedge clk) arm_req <= 1'b1;
      tick(100);
      check("armed", 16'h0001, armed);
      check("main_event", 16'h0001, main_event);
      @(posedge clk) arm_req <= 1'b0;
      tick(700);
      check("triggered", 16'h0000, triggered);
      check("main_event", 16'h0000, main_event);
      check("event_flag", 16'h0001, event_flag);
      @(posedge clk) evt_cfg.ext_care <= 1'b1;
      ext <= 1'b1;
      tick(10);
      check("event_flag", 16'h0000, event_flag);
      @(posedge clk) probe <= 8'h00;
      ext <= 1'b0;
      tick(10);
      @(posedge clk) probe <= 8'h10;
      wait_trig(40, 8'h10);
      check("halt_out", 16'h0000, halt_out);
      @(posedge clk) trig_req <= 1'b1;
      tick(5);
      check("halt_out", 16'h0000, halt_out);
      tick(120);
      check("halt_out", 16'h0001, halt_out);
      @(posedge clk) user_stop <= 1'b1;
      run <= 1'b0;
      @(posedge clk) user_stop <= 1'b0;
      sync_mode <= 1'b1;
      unconditional <= 1'b1;
      evt_cfg <= '0;
      start <= 1'b1;
      @(posedge clk) start <= 1'b0;
      tick(200);
      check("triggered", 16'h0000, triggered);
      @(posedge clk) run <= 1'b1;
      wait_trig(80, 8'h10);
      give_verdict;
   end
endmodule : testbench

bind async_timing_capture_trigger capture_props #(.EXP_MAX(EXP_MAX), .HALT_W(HALT_W)) i_capture_props (
   .clk(clk), .rst_n(rst_n), .tb_cfg(tb_cfg), .halt_enable(halt_enable), .sample_valid(sample_valid),
   .sample_mark(sample_mark), .armed(armed), .trig_pulse(trig_pulse), .triggered(triggered),
   .period_error(period_error), .acq_running(acq_running), .halt_out(halt_out));
